// File: logic/cfs_defs.svh
// How it works
// [R1] encoder supply short sets the supply fault flag.
// [R2] output one short, wire break or overtemperature sets output fault.
// [R3] both fault flags stay latched until fault acknowledge or controller stop clears them.
// [R4] more than one load control bit together sets the load fault.
// [R5] an invalid load value is rejected, setting kept, load fault set.
// [R6] parameter errors appear on a dedicated fault flag.
// [R7] status clear active shows a requested flag clear is in progress.
// [R8] compare flags set while output on, hold, clear only by clear.
// [R9] a compare flag cleared while its output is on sets again.
// [R10] manual switch of disabled output one sets compare one flag.
// [R11] manual switch of disabled output two sets compare two flag.
// [R12] the external input level is mirrored in every mode.
// [R13] the physical output one state is reported.
// [R14] the virtual output two state is reported.
// [R15] gate flag shows the internal gate open and counting.
// [R16] load busy shows a load function being executed.
// [R17] zero pass without main direction sets a flag held until clear.
// [R18] upper and lower limit violations latch until cleared.
// [R19] successful synchronization sets a flag held until clear.
// [R20] flags clear by request from controller answered by active bit.
// [R21] load fault holds while conflicting load bits stay set.
// [R22] isochronous clear or load acceptance takes exactly four bus cycles.
// [R23] with steady acknowledge or stop, faults follow their cause.
// [R24] clear active drops only after the request is withdrawn.
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH
// isochronous completion length in bus cycles
`define CFS_ISO_BUS_CYCLES 4
// synchroniser depth for pin inputs
`define CFS_SYNC_STAGES 2
// sticky flag vector positions
`define CFS_STK_CMP1 0
`define CFS_STK_CMP2 1
`define CFS_STK_ZERO 2
`define CFS_STK_UPPER 3
`define CFS_STK_LOWER 4
`define CFS_STK_SYNC 5
`define CFS_STK_WIDTH 6
// pin vector positions
`define CFS_PIN_EXT 0
`define CFS_PIN_SUPPLY 1
`define CFS_PIN_OUT 2
`define CFS_PIN_WIDTH 3
// reset values
`define CFS_STK_RESET 6'h00
`define CFS_CNT_RESET 3'h0
`endif

// File: logic/cfs_pkg.sv
package cfs_pkg;
  // status clear handshake states
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,
    CLR_RUN = 2'b01,
    CLR_HOLD = 2'b10
  } cfs_clr_state_type;
  // load function states
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_BUSY = 2'b01,
    LD_DONE = 2'b10
  } cfs_ld_state_type;
endpackage : cfs_pkg

// File: logic/cfs_feedback.sv
`timescale 1ns/1ps
`include "cfs_defs.svh"
module cfs_feedback import cfs_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // pins, asynchronous
  input wire logic external_input_pin_i,
  input wire logic supply_short_i,
  input wire logic output_one_short_i,
  input wire logic output_one_open_i,
  input wire logic output_one_hot_i,
  // controller control bits
  input wire logic fault_acknowledge_i,
  input wire logic controller_stop_i,
  input wire logic status_clear_request_i,
  input wire logic load_count_now_i,
  input wire logic load_count_staged_i,
  input wire logic load_compare_one_i,
  input wire logic load_compare_two_i,
  input wire logic output_param_change_i,
  input wire logic manual_output_one_i,
  input wire logic manual_output_two_i,
  input wire logic output_one_enable_i,
  input wire logic output_two_enable_i,
  input wire logic isochronous_i,
  input wire logic bus_cycle_i,
  // counting core events and states
  input wire logic load_value_bad_i,
  input wire logic param_error_i,
  input wire logic output_one_pin_i,
  input wire logic output_two_virtual_i,
  input wire logic gate_open_i,
  input wire logic dir_up_i,
  input wire logic dir_down_i,
  input wire logic no_main_direction_i,
  input wire logic zero_cross_i,
  input wire logic upper_exceed_i,
  input wire logic lower_exceed_i,
  input wire logic sync_success_i,
  // load function to the core
  output logic load_accept_o,
  output logic [4:0] load_select_o,
  // feedback bits
  output logic encoder_supply_fault_o,
  output logic output_one_fault_o,
  output logic load_fault_o,
  output logic parameter_fault_o,
  output logic status_clear_active_o,
  output logic counting_upward_o,
  output logic counting_downward_o,
  output logic compare_one_hit_o,
  output logic compare_two_hit_o,
  output logic aux_input_level_o,
  output logic output_one_state_o,
  output logic output_two_state_o,
  output logic gate_open_flag_o,
  output logic load_busy_o,
  output logic zero_pass_flag_o,
  output logic upper_limit_flag_o,
  output logic lower_limit_flag_o,
  output logic sync_done_flag_o
);
  localparam logic [2:0] ISO_LAST = 3'(`CFS_ISO_BUS_CYCLES - 1);

  logic [`CFS_PIN_WIDTH-1:0] pin_raw;
  logic [`CFS_PIN_WIDTH-1:0] pin_s;
  logic [`CFS_STK_WIDTH-1:0] stk;
  logic [`CFS_STK_WIDTH-1:0] stk_set;
  logic [4:0] ld_bits;
  logic ld_conflict;
  logic ld_single;
  logic stk_clear;
  logic fault_release;
  cfs_clr_state_type clr_state;
  cfs_clr_state_type next_clr_state;
  cfs_ld_state_type ld_state;
  cfs_ld_state_type next_ld_state;
  logic [2:0] clr_cnt;
  logic [2:0] ld_cnt;
  logic ld_reject;
  logic ld_finish;
  logic clr_finish;

  // output fault causes merge before syncing, all are level faults
  assign pin_raw[`CFS_PIN_EXT] = external_input_pin_i;
  assign pin_raw[`CFS_PIN_SUPPLY] = supply_short_i;
  assign pin_raw[`CFS_PIN_OUT] = output_one_short_i | output_one_open_i
    | output_one_hot_i;

  // two-stage synchronisers, first stage read by nothing else
  genvar gp;
  generate
    for (gp = 0; gp < `CFS_PIN_WIDTH; gp++) begin : g_sync
      logic [`CFS_SYNC_STAGES-1:0] sh;
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sh <= '0;
        end else begin
          sh <= {sh[`CFS_SYNC_STAGES-2:0], pin_raw[gp]};
        end
      end
      assign pin_s[gp] = sh[`CFS_SYNC_STAGES-1];
    end
  endgenerate

  // latched faults: steady ack or stop turns them into cause followers
  assign fault_release = fault_acknowledge_i | controller_stop_i; // see [R23]
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      encoder_supply_fault_o <= 1'b0;
      output_one_fault_o <= 1'b0;
    end else begin
      encoder_supply_fault_o <= pin_s[`CFS_PIN_SUPPLY] // see [R1]
        | (encoder_supply_fault_o & ~fault_release); // see [R3]
      output_one_fault_o <= pin_s[`CFS_PIN_OUT] // see [R2]
        | (output_one_fault_o & ~fault_release); // see [R3]
    end
  end

  // status clear handshake, four phases
  always_comb begin
    next_clr_state = clr_state;
    clr_finish = 1'b0;
    case (clr_state)
      CLR_IDLE: begin
        if (status_clear_request_i) begin
          next_clr_state = CLR_RUN; // see [R20]
        end
      end
      CLR_RUN: begin
        // isochronous mode waits a fixed count of bus cycles
        clr_finish = !isochronous_i
          || (bus_cycle_i && clr_cnt == ISO_LAST); // see [R22]
        if (clr_finish) begin
          next_clr_state = CLR_HOLD;
        end
      end
      CLR_HOLD: begin
        if (!status_clear_request_i) begin
          next_clr_state = CLR_IDLE; // see [R24]
        end
      end
      default: next_clr_state = CLR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clr_state <= CLR_IDLE;
      clr_cnt <= `CFS_CNT_RESET;
    end else begin
      clr_state <= next_clr_state;
      if (clr_state != CLR_RUN) begin
        clr_cnt <= `CFS_CNT_RESET;
      end else if (bus_cycle_i) begin
        clr_cnt <= clr_cnt + 3'h1;
      end
    end
  end

  assign stk_clear = (clr_state == CLR_RUN);
  assign status_clear_active_o = (clr_state != CLR_IDLE); // see [R7]

  // sticky flag causes
  assign stk_set[`CFS_STK_CMP1] = output_one_pin_i // see [R8]
    | (manual_output_one_i & ~output_one_enable_i); // see [R10]
  assign stk_set[`CFS_STK_CMP2] = output_two_virtual_i // see [R8]
    | (manual_output_two_i & ~output_two_enable_i); // see [R11]
  assign stk_set[`CFS_STK_ZERO] = zero_cross_i // see [R17]
    & no_main_direction_i;
  assign stk_set[`CFS_STK_UPPER] = upper_exceed_i; // see [R18]
  assign stk_set[`CFS_STK_LOWER] = lower_exceed_i; // see [R18]
  assign stk_set[`CFS_STK_SYNC] = sync_success_i; // see [R19]

  // set beats clear so a live output re-raises its flag at once
  genvar gs;
  generate
    for (gs = 0; gs < `CFS_STK_WIDTH; gs++) begin : g_stk
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          stk[gs] <= 1'b0;
        end else begin
          stk[gs] <= stk_set[gs] | (stk[gs] & ~stk_clear); // see [R9]
        end
      end
    end
  endgenerate

  assign compare_one_hit_o = stk[`CFS_STK_CMP1];
  assign compare_two_hit_o = stk[`CFS_STK_CMP2];
  assign zero_pass_flag_o = stk[`CFS_STK_ZERO];
  assign upper_limit_flag_o = stk[`CFS_STK_UPPER];
  assign lower_limit_flag_o = stk[`CFS_STK_LOWER];
  assign sync_done_flag_o = stk[`CFS_STK_SYNC];

  // mirrored states, registered for clean feedback
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aux_input_level_o <= 1'b0;
      output_one_state_o <= 1'b0;
      output_two_state_o <= 1'b0;
      gate_open_flag_o <= 1'b0;
      counting_upward_o <= 1'b0;
      counting_downward_o <= 1'b0;
      parameter_fault_o <= 1'b0;
    end else begin
      aux_input_level_o <= pin_s[`CFS_PIN_EXT]; // see [R12]
      output_one_state_o <= output_one_pin_i; // see [R13]
      output_two_state_o <= output_two_virtual_i; // see [R14]
      gate_open_flag_o <= gate_open_i; // see [R15]
      counting_upward_o <= dir_up_i;
      counting_downward_o <= dir_down_i;
      parameter_fault_o <= param_error_i; // see [R6]
    end
  end

  // load request decode
  assign ld_bits = {output_param_change_i, load_compare_two_i,
    load_compare_one_i, load_count_staged_i, load_count_now_i};
  assign ld_conflict = ($countones(ld_bits) > 1); // see [R4]
  assign ld_single = ($countones(ld_bits) == 1);

  // load function sequencing; done waits for request withdrawal
  always_comb begin
    next_ld_state = ld_state;
    ld_reject = 1'b0;
    ld_finish = 1'b0;
    case (ld_state)
      LD_IDLE: begin
        if (ld_single && load_value_bad_i) begin
          ld_reject = 1'b1; // see [R5]
          next_ld_state = LD_DONE;
        end else if (ld_single) begin
          next_ld_state = LD_BUSY;
        end
      end
      LD_BUSY: begin
        ld_finish = !isochronous_i
          || (bus_cycle_i && ld_cnt == ISO_LAST); // see [R22]
        if (ld_conflict || ld_finish) begin
          next_ld_state = LD_DONE;
        end
      end
      LD_DONE: begin
        if (ld_bits == 5'h00) begin
          next_ld_state = LD_IDLE;
        end
      end
      default: next_ld_state = LD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ld_state <= LD_IDLE;
      ld_cnt <= `CFS_CNT_RESET;
    end else begin
      ld_state <= next_ld_state;
      if (ld_state != LD_BUSY) begin
        ld_cnt <= `CFS_CNT_RESET;
      end else if (bus_cycle_i) begin
        ld_cnt <= ld_cnt + 3'h1;
      end
    end
  end

  assign load_busy_o = (ld_state == LD_BUSY); // see [R16]

  // accept pulse and the selected target toward the core
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_accept_o <= 1'b0;
      load_select_o <= 5'h00;
    end else begin
      load_accept_o <= ld_finish && !ld_conflict;
      if (ld_state == LD_IDLE && ld_single && !load_value_bad_i) begin
        load_select_o <= ld_bits;
      end
    end
  end

  // only a correct acceptance removes the load fault; set wins
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_fault_o <= 1'b0;
    end else begin
      load_fault_o <= ld_conflict | ld_reject // see [R21]
        | (load_fault_o & ~(ld_finish & ~ld_conflict));
    end
  end

  // checks share the core clock and hold off during reset
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_clr_start;
    clr_state == CLR_IDLE && status_clear_request_i;
  endsequence
  sequence s_clr_answer;
    ##1 status_clear_active_o;
  endsequence

  a_supply_set: assert property (pin_s[`CFS_PIN_SUPPLY] |=> // see [R1]
    encoder_supply_fault_o) else $error("supply fault not raised");
  a_outfault_set: assert property (pin_s[`CFS_PIN_OUT] |=> // see [R2]
    output_one_fault_o) else $error("output fault not raised");
  a_fault_latch: assert property (encoder_supply_fault_o // see [R3]
    && !fault_release |=> encoder_supply_fault_o)
    else $error("supply fault dropped without ack");
  a_fault_follow: assert property (fault_release // see [R23]
    && !pin_s[`CFS_PIN_OUT] |=> !output_one_fault_o)
    else $error("output fault kept under steady ack");
  a_load_conflict: assert property (ld_conflict |=> // see [R4]
    load_fault_o && !load_accept_o) else $error("load conflict not flagged");
  a_load_reject: assert property (ld_state == LD_IDLE // see [R5]
    && ld_single && load_value_bad_i |=> load_fault_o && !load_busy_o [*2])
    else $error("bad load value accepted");
  a_cmp_reraise: assert property (output_one_pin_i |=> // see [R9]
    compare_one_hit_o) else $error("compare one flag not set by live output");
  a_manual_two: assert property (manual_output_two_i // see [R11]
    && !output_two_enable_i |=> compare_two_hit_o)
    else $error("manual use of disabled output two missed");
  a_input_mirror: assert property (##1 aux_input_level_o // see [R12]
    == $past(pin_s[`CFS_PIN_EXT])) else $error("input level not mirrored");
  a_clear_answer: assert property (s_clr_start |-> s_clr_answer) // see [R20]
    else $error("clear request not answered");
  a_clear_hold: assert property (status_clear_active_o // see [R24]
    && status_clear_request_i |=> status_clear_active_o)
    else $error("clear active dropped before request");
  a_iso_count: assert property (clr_state == CLR_RUN // see [R22]
    && next_clr_state == CLR_HOLD && isochronous_i
    |-> clr_cnt == ISO_LAST && bus_cycle_i)
    else $error("isochronous clear length wrong");
  a_zero_hold: assert property (zero_pass_flag_o && !stk_clear // see [R17]
    |=> zero_pass_flag_o) else $error("zero pass flag lost");
endmodule : cfs_feedback

// File: sim/cfs_controller_model.sv
`timescale 1ns/1ps
module cfs_controller_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // commands from the bench
  input wire logic clear_go_i,
  input wire logic [3:0] clear_hold_i,
  output logic clear_done_o,
  // handshake with the device
  input wire logic status_clear_active_i,
  output logic status_clear_request_o
);
  int n;
  // four-phase clear; request moves only after a falling edge
  initial begin
    status_clear_request_o = 1'b0;
    clear_done_o = 1'b0;
    forever begin
      @(negedge core_clk_i);
      if (clear_go_i && nrst_i && !clear_done_o) begin
        status_clear_request_o = 1'b1;
        n = 0;
        while (status_clear_active_i !== 1'b1 && n < 300) begin
          @(negedge core_clk_i);
          n++;
        end
        // a slow controller keeps the request up a while longer
        repeat (clear_hold_i) @(negedge core_clk_i);
        status_clear_request_o = 1'b0;
        n = 0;
        while (status_clear_active_i !== 1'b0 && n < 300) begin
          @(negedge core_clk_i);
          n++;
        end
        clear_done_o = 1'b1;
      end else if (!clear_go_i) begin
        clear_done_o = 1'b0;
      end
    end
  end
endmodule : cfs_controller_model

// File: sim/counter_feedback_status_logic_tb_top.sv
`timescale 1ns/1ps
module counter_feedback_status_logic_tb_top;
  logic core_clk_i, nrst_i, external_input_pin_i, supply_short_i;
  logic output_one_short_i, output_one_open_i, output_one_hot_i;
  logic fault_acknowledge_i, controller_stop_i, status_clear_request_i;
  logic load_count_now_i, load_count_staged_i, load_compare_one_i;
  logic load_compare_two_i, output_param_change_i, manual_output_one_i;
  logic manual_output_two_i, output_one_enable_i, output_two_enable_i;
  logic isochronous_i, bus_cycle_i, load_value_bad_i, param_error_i;
  logic output_one_pin_i, output_two_virtual_i, gate_open_i, dir_up_i;
  logic dir_down_i, no_main_direction_i, zero_cross_i, upper_exceed_i;
  logic lower_exceed_i, sync_success_i, load_accept_o, clear_go, clear_done;
  logic [4:0] load_select_o, ld;
  logic [3:0] clear_hold;
  logic encoder_supply_fault_o, output_one_fault_o, load_fault_o;
  logic parameter_fault_o, status_clear_active_o, counting_upward_o;
  logic counting_downward_o, compare_one_hit_o, compare_two_hit_o;
  logic aux_input_level_o, output_one_state_o, output_two_state_o;
  logic gate_open_flag_o, load_busy_o, zero_pass_flag_o, upper_limit_flag_o;
  logic lower_limit_flag_o, sync_done_flag_o;
  logic [31:0] r;
  int failures, checks, acc_n, bus_n, cyc, a0, b0;
  logic [7:0] exp_q[$];

  assign {output_param_change_i, load_compare_two_i, load_compare_one_i,
    load_count_staged_i, load_count_now_i} = ld;

  cfs_feedback u_cfs_feedback (.core_clk_i, .nrst_i, .external_input_pin_i,
    .supply_short_i, .output_one_short_i, .output_one_open_i,
    .output_one_hot_i, .fault_acknowledge_i, .controller_stop_i,
    .status_clear_request_i, .load_count_now_i, .load_count_staged_i,
    .load_compare_one_i, .load_compare_two_i, .output_param_change_i,
    .manual_output_one_i, .manual_output_two_i, .output_one_enable_i,
    .output_two_enable_i, .isochronous_i, .bus_cycle_i, .load_value_bad_i,
    .param_error_i, .output_one_pin_i, .output_two_virtual_i, .gate_open_i,
    .dir_up_i, .dir_down_i, .no_main_direction_i, .zero_cross_i,
    .upper_exceed_i, .lower_exceed_i, .sync_success_i, .load_accept_o,
    .load_select_o, .encoder_supply_fault_o, .output_one_fault_o,
    .load_fault_o, .parameter_fault_o, .status_clear_active_o,
    .counting_upward_o, .counting_downward_o, .compare_one_hit_o,
    .compare_two_hit_o, .aux_input_level_o, .output_one_state_o,
    .output_two_state_o, .gate_open_flag_o, .load_busy_o, .zero_pass_flag_o,
    .upper_limit_flag_o, .lower_limit_flag_o, .sync_done_flag_o);

  cfs_controller_model u_cfs_controller_model (.core_clk_i, .nrst_i,
    .clear_go_i(clear_go), .clear_hold_i(clear_hold),
    .clear_done_o(clear_done), .status_clear_active_i(status_clear_active_o),
    .status_clear_request_o(status_clear_request_i));

  // 200 mhz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // bus cycle pulse every third cycle, only in isochronous mode
  always @(negedge core_clk_i) begin
    cyc++;
    bus_cycle_i <= isochronous_i && (cyc % 3 == 0);
  end

  // counters read at the rising edge see the pre-edge outputs
  always @(posedge core_clk_i) begin
    if (load_accept_o === 1'b1) acc_n++;
    if (load_busy_o === 1'b1 && bus_cycle_i === 1'b1) bus_n++;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic do_clear(input logic [3:0] hold);
    int n;
    int act;
    n = 0;
    act = 0;
    clear_hold = hold;
    clear_go = 1'b1;
    while (clear_done !== 1'b1 && n < 300) begin
      @(negedge core_clk_i);
      n++;
      if (status_clear_active_o === 1'b1) act++;
    end
    chk("clear_done", 8'h01, 8'(clear_done));
    chk("active_held", 8'h01, 8'(act > hold));
    clear_go = 1'b0;
    tick(1);
    chk("active_low", 8'h00, 8'(status_clear_active_o));
  endtask : do_clear

  task automatic do_load(input int i);
    int n;
    int b;
    n = 0;
    b = 0;
    a0 = acc_n;
    ld = 5'h01 << i;
    while (load_busy_o !== 1'b1 && n < 300) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("load_select", 8'(5'h01 << i), 8'(load_select_o));
    while (load_busy_o === 1'b1 && n < 300) begin
      @(negedge core_clk_i);
      n++;
      b++;
    end
    if (!isochronous_i) chk("busy_len", 8'h01, 8'(b));
    tick(2);
    chk("accepts", 8'h01, 8'(acc_n - a0));
    chk("load_fault", 8'h00, 8'(load_fault_o));
    ld = 5'h00;
    tick(2);
  endtask : do_load

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // a full run takes under a thousand cycles
  initial begin
    #(4000 * 5);
    failures++;
    summarize();
  end

  initial begin
    {nrst_i, external_input_pin_i, supply_short_i, output_one_short_i,
      output_one_open_i, output_one_hot_i, fault_acknowledge_i,
      controller_stop_i, manual_output_one_i, manual_output_two_i,
      output_one_enable_i, output_two_enable_i, isochronous_i,
      load_value_bad_i, param_error_i, output_one_pin_i, output_two_virtual_i,
      gate_open_i, dir_up_i, dir_down_i, no_main_direction_i, zero_cross_i,
      upper_exceed_i, lower_exceed_i, sync_success_i} = '0;
    {ld, clear_go, clear_hold, failures, checks} = '0;
    r = $urandom(32'h8625deea);
    repeat (2) @(posedge core_clk_i);
    tick(1);
    nrst_i = 1'b1;
    tick(1);
    chk("reset", 8'h00, {encoder_supply_fault_o, output_one_fault_o,
      load_fault_o, parameter_fault_o, status_clear_active_o, load_busy_o,
      load_accept_o, compare_one_hit_o});
    // random levels on the mirrored inputs, expectations queued
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      {external_input_pin_i, output_one_pin_i, output_two_virtual_i,
        gate_open_i, dir_up_i, dir_down_i} = r[5:0];
      exp_q.push_back({2'b00, r[5:0]});
      tick(4);
      chk("mirrors", exp_q.pop_front(), {2'b00, aux_input_level_o,
        output_one_state_o, output_two_state_o, gate_open_flag_o,
        counting_upward_o,
        counting_downward_o});
    end
    {external_input_pin_i, output_one_pin_i, output_two_virtual_i} = 3'h0;
    tick(2);
    do_clear(4'h0);
    $display("test mirrors done");
    // zero crossing counts only without a main direction
    zero_cross_i = 1'b1;
    tick(1);
    zero_cross_i = 1'b0;
    tick(2);
    chk("zero_dir", 8'h00, 8'(zero_pass_flag_o));
    no_main_direction_i = 1'b1;
    {zero_cross_i, upper_exceed_i, lower_exceed_i, sync_success_i,
      output_one_pin_i, output_two_virtual_i} = 6'h3f;
    tick(1);
    {zero_cross_i, upper_exceed_i, lower_exceed_i, sync_success_i,
      output_one_pin_i, output_two_virtual_i} = 6'h00;
    tick(3);
    chk("sticky", 8'h3f, {2'b00, zero_pass_flag_o, upper_limit_flag_o,
      lower_limit_flag_o, sync_done_flag_o, compare_one_hit_o,
      compare_two_hit_o});
    output_one_pin_i = 1'b1;
    do_clear(4'h3);
    tick(2);
    chk("resticky", 8'h02, {2'b00, zero_pass_flag_o, upper_limit_flag_o,
      lower_limit_flag_o, sync_done_flag_o, compare_one_hit_o,
      compare_two_hit_o});
    output_one_pin_i = 1'b0;
    tick(2);
    do_clear(4'h0);
    {manual_output_one_i, manual_output_two_i} = 2'b11;
    tick(3);
    chk("manual", 8'h03, {6'h00, compare_one_hit_o,
      compare_two_hit_o});
    {manual_output_one_i, manual_output_two_i} = 2'b00;
    tick(2);
    do_clear(4'h1);
    $display("test sticky flags done");
    // each fault cause latches until acknowledged
    for (int j = 0; j < 3; j++) begin
      supply_short_i = 1'b1;
      {output_one_hot_i, output_one_open_i, output_one_short_i} = 3'h1 << j;
      tick(4);
      {supply_short_i, output_one_hot_i, output_one_open_i,
        output_one_short_i} = 4'h0;
      tick(4);
      chk("faults_held", 8'h03, {6'h00, encoder_supply_fault_o,
        output_one_fault_o});
      fault_acknowledge_i = 1'b1;
      tick(1);
      fault_acknowledge_i = 1'b0;
      tick(1);
      chk("faults_acked", 8'h00, {6'h00, encoder_supply_fault_o,
        output_one_fault_o});
    end
    // steady acknowledge, then controller stop
    for (int m = 0; m < 2; m++) begin
      {controller_stop_i, fault_acknowledge_i} = (m == 0) ? 2'b01 : 2'b10;
      supply_short_i = 1'b1;
      tick(4);
      chk("follow_set", 8'h01, 8'(encoder_supply_fault_o));
      supply_short_i = 1'b0;
      tick(4);
      chk("follow_clr", 8'h00, 8'(encoder_supply_fault_o));
    end
    {controller_stop_i, fault_acknowledge_i} = 2'b00;
    param_error_i = 1'b1;
    tick(2);
    chk("param_set", 8'h01, 8'(parameter_fault_o));
    param_error_i = 1'b0;
    tick(2);
    chk("param_clr", 8'h00, 8'(parameter_fault_o));
    $display("test faults done");
    for (int i = 0; i < 5; i++) do_load(i);
    // bad value: refused, no busy, no accept
    a0 = acc_n;
    load_value_bad_i = 1'b1;
    ld = 5'h02;
    tick(3);
    // fault is the upper bit, busy the lower
    chk("bad_value", 8'h02, {6'h00, load_fault_o, load_busy_o});
    {ld, load_value_bad_i} = 6'h00;
    tick(2);
    chk("bad_no_acc", 8'h00, 8'(acc_n - a0));
    do_load(0);
    // two load bits together
    a0 = acc_n;
    ld = 5'h18;
    for (int k = 0; k < 4; k++) begin
      tick(1);
      if (k > 0) chk("conflict", 8'h01, 8'(load_fault_o));
    end
    ld = 5'h00;
    tick(2);
    chk("conf_no_acc", 8'h00, 8'(acc_n - a0));
    do_load(2);
    $display("test load done");
    isochronous_i = 1'b1;
    // snapshot, the counter has its own process
    b0 = bus_n;
    do_load(3);
    chk("iso_cycles", 8'h04, 8'(bus_n - b0));
    do_clear(4'h0);
    isochronous_i = 1'b0;
    $display("test isochronous done");
    summarize();
  end
endmodule : counter_feedback_status_logic_tb_top
